// ==== src/sslc_ctrl.sv ====
// Sleep state controller: running, stop-grant and sleep clock gating
//
// Operation
// - Sleep is entered from the sleep request only while in stop-grant.
// - In sleep all unit clocks stop; only the PLL and bus clock enables stay on.
// - In sleep, snoops are not answered and interrupts not accepted.
// - In sleep only sleep release and reset are recognised; stop-clock is ignored.
// - Sleep request release returns to stop-grant, restarting bus and APIC clocks.
// - Stop-clock request issues a grant acknowledge and stops core clocks in the same cycle.
// - Stop-grant keeps snoops and interrupts; stop-clock release resumes all clocks.
// - Stop-clock request is synchronised internally; the bus clock is untouched.
`timescale 1ns/1ps
`default_nettype none
module sslc_ctrl (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic clock_stop_request_n_in,
  input wire logic sleep_request_n_in,
  input wire logic snoop_in,
  input wire logic interrupt_in,
  output logic grant_ack_out,
  output logic [2:0] clock_enable_out,
  output logic pll_enable_out,
  output logic bus_clock_enable_out,
  output logic snoop_enable_out,
  output logic snoop_taken_out,
  output logic interrupt_taken_out,
  output logic executing_out,
  output logic sleeping_out
);
  sslc_pkg::sslc_state_type state;
  sslc_pkg::sslc_state_type next_state;
  sslc_sync_if req_if ();

  // ----------------------------------------
  // Request synchronisation
  // ----------------------------------------
  sslc_sync u_sync (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .clock_stop_request_n_in(clock_stop_request_n_in),
    .sleep_request_n_in(sleep_request_n_in),
    .sync_out(req_if.producer)
  );

  // ----------------------------------------
  // State transitions
  // ----------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      sslc_pkg::st_run: begin
        if (req_if.stop_req) begin
          next_state = sslc_pkg::st_grant;
        end
      end
      sslc_pkg::st_grant: begin
        if (req_if.sleep_req) begin
          next_state = sslc_pkg::st_sleep;
        end else if (!req_if.stop_req) begin
          next_state = sslc_pkg::st_run;
        end
      end
      sslc_pkg::st_sleep: begin
        // Only sleep release leaves; snoop and interrupt are unseen
        if (!req_if.sleep_req) begin
          next_state = sslc_pkg::st_grant;
        end
      end
      default: begin
        next_state = sslc_pkg::st_run;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= sslc_pkg::st_run;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Grant acknowledge transaction
  // ----------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      grant_ack_out <= 1'b0;
    end else begin
      grant_ack_out <= (state == sslc_pkg::st_run) && req_if.stop_req;
    end
  end

  // ----------------------------------------
  // Clock gating and responses
  // ----------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clock_enable_out <= sslc_pkg::gate_all;
    end else begin
      unique case (next_state)
        sslc_pkg::st_run: clock_enable_out <= sslc_pkg::gate_all;
        sslc_pkg::st_grant: clock_enable_out <= sslc_pkg::gate_grant;
        sslc_pkg::st_sleep: clock_enable_out <= sslc_pkg::gate_none;
        default: clock_enable_out <= sslc_pkg::gate_all;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      snoop_taken_out <= 1'b0;
      interrupt_taken_out <= 1'b0;
    end else begin
      snoop_taken_out <= snoop_in && (state != sslc_pkg::st_sleep);
      interrupt_taken_out <= interrupt_in && (state != sslc_pkg::st_sleep);
    end
  end

  assign pll_enable_out = 1'b1;
  assign bus_clock_enable_out = 1'b1;
  assign snoop_enable_out = state != sslc_pkg::st_sleep;
  assign executing_out = state == sslc_pkg::st_run;
  assign sleeping_out = state == sslc_pkg::st_sleep;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_in_grant;
    state == sslc_pkg::st_grant;
  endsequence

  sequence s_sleep_req;
    req_if.sleep_req;
  endsequence

  sequence s_stop_seen;
    executing_out && req_if.stop_req;
  endsequence

  sequence s_sleep_release;
    sleeping_out && !req_if.sleep_req;
  endsequence

  a_sleep_entry_grant: assert property (@(posedge clock_in)
    disable iff (!nrst_in) $rose(sleeping_out) |-> $past(state) == sslc_pkg::st_grant)
    else $error("sleep entered from a state other than stop-grant");

  a_run_no_sleep: assert property (@(posedge clock_in)
    disable iff (!nrst_in) executing_out |=> !sleeping_out)
    else $error("sleep entered straight from running");

  a_grant_to_sleep: assert property (@(posedge clock_in)
    disable iff (!nrst_in) s_in_grant ##0 s_sleep_req |=> sleeping_out)
    else $error("sleep request in stop-grant ignored");

  a_sleep_sync_delay: assert property (@(posedge clock_in)
    disable iff (!nrst_in)
    s_in_grant ##0 $fell(sleep_request_n_in) ##1 s_in_grant |=> req_if.sleep_req)
    else $error("sleep request synchroniser delay wrong");

  a_sleep_gate_off: assert property (@(posedge clock_in)
    disable iff (!nrst_in)
    sleeping_out |-> clock_enable_out == sslc_pkg::gate_none && pll_enable_out)
    else $error("clocks not stopped in sleep");

  a_sleep_no_snoop: assert property (@(posedge clock_in)
    disable iff (!nrst_in) sleeping_out |=> !snoop_taken_out && !interrupt_taken_out)
    else $error("snoop or interrupt taken in sleep");

  a_sleep_snoop_off: assert property (@(posedge clock_in)
    disable iff (!nrst_in) sleeping_out |-> !snoop_enable_out)
    else $error("snoop enable left on in sleep");

  a_sleep_holds_req: assert property (@(posedge clock_in)
    disable iff (!nrst_in) sleeping_out && req_if.sleep_req |=> sleeping_out)
    else $error("sleep left while sleep request held");

  a_sleep_stop_ignored: assert property (@(posedge clock_in)
    disable iff (!nrst_in)
    sleeping_out && req_if.sleep_req && !req_if.stop_req |=> sleeping_out && !grant_ack_out)
    else $error("stop-clock release acted on in sleep");

  a_sleep_exit_grant: assert property (@(posedge clock_in)
    disable iff (!nrst_in)
    s_sleep_release |=> s_in_grant ##0 clock_enable_out == sslc_pkg::gate_grant)
    else $error("sleep exit did not return to stop-grant");

  a_grant_ack_pulse: assert property (@(posedge clock_in)
    disable iff (!nrst_in) s_stop_seen |=> s_in_grant ##0 grant_ack_out ##1 !grant_ack_out)
    else $error("grant acknowledge missing or not one cycle");

  a_ack_from_run: assert property (@(posedge clock_in)
    disable iff (!nrst_in) grant_ack_out |-> s_in_grant ##0 $past(executing_out))
    else $error("grant acknowledge outside stop-grant entry");

  a_grant_keeps_units: assert property (@(posedge clock_in)
    disable iff (!nrst_in)
    s_in_grant |-> clock_enable_out[sslc_pkg::gate_bus] &&
    clock_enable_out[sslc_pkg::gate_apic] && !clock_enable_out[sslc_pkg::gate_core])
    else $error("wrong unit clocks in stop-grant");

  a_grant_resume: assert property (@(posedge clock_in)
    disable iff (!nrst_in)
    s_in_grant ##0 !req_if.stop_req && !req_if.sleep_req |=>
    executing_out && clock_enable_out == sslc_pkg::gate_all)
    else $error("stop-clock release did not resume");

  a_run_all_clocks: assert property (@(posedge clock_in)
    disable iff (!nrst_in) executing_out |-> clock_enable_out == sslc_pkg::gate_all)
    else $error("unit clock stopped while running");

  a_grant_services: assert property (@(posedge clock_in)
    disable iff (!nrst_in)
    s_in_grant |=> snoop_taken_out == $past(snoop_in) &&
    interrupt_taken_out == $past(interrupt_in))
    else $error("snoop or interrupt dropped in stop-grant");

  a_stop_sync_delay: assert property (@(posedge clock_in)
    disable iff (!nrst_in)
    executing_out && $fell(clock_stop_request_n_in) ##1 executing_out |=> req_if.stop_req)
    else $error("stop request synchroniser delay wrong");

  a_bus_clock_on: assert property (@(posedge clock_in)
    disable iff (!nrst_in)
    !sleeping_out |-> bus_clock_enable_out && clock_enable_out[sslc_pkg::gate_bus])
    else $error("bus clock disturbed outside sleep");

  a_reset_to_run: assert property (@(posedge clock_in)
    $rose(nrst_in) |-> executing_out)
    else $error("controller not running after reset");
endmodule
`default_nettype wire

// ==== src/sslc_pkg.sv ====
// Package of constants and types for the sleep state controller
package sslc_pkg;
  // ----------------------------------------
  // Power states
  // ----------------------------------------
  typedef enum logic [2:0] {
    st_run   = 3'b001,
    st_grant = 3'b010,
    st_sleep = 3'b100
  } sslc_state_type;

  // ----------------------------------------
  // Clock gate vector layout
  // ----------------------------------------
  localparam int unsigned gate_bus = 0;
  localparam int unsigned gate_apic = 1;
  localparam int unsigned gate_core = 2;
  localparam int unsigned gate_width = 3;
  localparam logic [2:0] gate_all = 3'h7;
  localparam logic [2:0] gate_grant = 3'h3;
  localparam logic [2:0] gate_none = 3'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned sync_stages = 2;
  localparam logic [1:0] sync_reset = 2'h3;
endpackage

// ==== src/sslc_sync_if.sv ====
// Interface carrying synchronised request levels
`timescale 1ns/1ps
`default_nettype none
interface sslc_sync_if;
  logic stop_req;
  logic sleep_req;
  modport producer (output stop_req, output sleep_req);
  modport consumer (input stop_req, input sleep_req);
endinterface
`default_nettype wire

// ==== src/sslc_sync.sv ====
// Two-stage synchroniser for the active-low request inputs
`timescale 1ns/1ps
`default_nettype none
module sslc_sync (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic clock_stop_request_n_in,
  input wire logic sleep_request_n_in,
  sslc_sync_if.producer sync_out
);
  logic [sslc_pkg::sync_stages-1:0] stop_meta;
  logic [sslc_pkg::sync_stages-1:0] sleep_meta;

  // ----------------------------------------
  // Synchronisers, reset to deasserted (high)
  // ----------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stop_meta <= sslc_pkg::sync_reset;
    end else begin
      stop_meta <= {stop_meta[sslc_pkg::sync_stages-2:0], clock_stop_request_n_in};
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sleep_meta <= sslc_pkg::sync_reset;
    end else begin
      sleep_meta <= {sleep_meta[sslc_pkg::sync_stages-2:0], sleep_request_n_in};
    end
  end

  assign sync_out.stop_req = ~stop_meta[sslc_pkg::sync_stages-1];
  assign sync_out.sleep_req = ~sleep_meta[sslc_pkg::sync_stages-1];
endmodule
`default_nettype wire

// ==== sim/sslc_chipset.sv ====
// Chipset-side model driving the power-management requests
`timescale 1ns/1ps
`default_nettype none
module sslc_chipset (
  input wire logic want_stop_in,
  input wire logic want_sleep_in,
  input wire logic early_sleep_in,
  input wire logic executing_in,
  output logic clock_stop_request_n_out,
  output logic sleep_request_n_out
);
  assign clock_stop_request_n_out = ~want_stop_in;
  // Sleep only once running has stopped, unless told to misbehave
  assign sleep_request_n_out = ~(want_sleep_in & (~executing_in | early_sleep_in));
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Testbench for the sleep state controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic want_stop = 1'b0;
  logic want_sleep = 1'b0;
  logic early = 1'b0;
  logic snoop = 1'b0;
  logic intr = 1'b0;
  logic stop_n, sleep_n, ack, pll, busclk, snp_en, snp_tk, int_tk, exe, slp;
  logic [2:0] clk_en;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;

  sslc_chipset sslc_chipset_i (.want_stop_in(want_stop), .want_sleep_in(want_sleep),
    .early_sleep_in(early), .executing_in(exe),
    .clock_stop_request_n_out(stop_n), .sleep_request_n_out(sleep_n));

  sslc_ctrl sslc_ctrl_i (.clock_in(clock_in), .nrst_in(nrst_in),
    .clock_stop_request_n_in(stop_n), .sleep_request_n_in(sleep_n),
    .snoop_in(snoop), .interrupt_in(intr), .grant_ack_out(ack),
    .clock_enable_out(clk_en), .pll_enable_out(pll), .bus_clock_enable_out(busclk),
    .snoop_enable_out(snp_en), .snoop_taken_out(snp_tk), .interrupt_taken_out(int_tk),
    .executing_out(exe), .sleeping_out(slp));

  initial begin
    forever #5 clock_in = ~clock_in;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clock_in) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      end_sim();
    end
  end

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  task automatic taken(input logic [1:0] exp);
    snoop = 1'b1;
    intr = 1'b1;
    step(1);
    snoop = 1'b0;
    intr = 1'b0;
    chk({2'h0, int_tk, snp_tk}, {2'h0, exp});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    step(3);
    nrst_in = 1'b1;
    step(1);
    chk({exe, clk_en}, 4'hf);
    chk({1'b0, snp_en, pll, busclk}, 4'h7);
    $display("Reset test done");
  endtask

  task automatic t_stop();
    want_stop = 1'b1;
    step(2);
    chk({3'h0, ack}, 4'h0);
    step(1);
    chk({ack, clk_en}, 4'hb);
    chk({2'h0, exe, busclk}, 4'h1);
    step(1);
    chk({3'h0, ack}, 4'h0);
    taken(2'h3);
    want_stop = 1'b0;
    step(3);
    chk({exe, clk_en}, 4'hf);
    $display("Stop-grant test done");
  endtask

  task automatic t_sleep();
    want_stop = 1'b1;
    step(4);
    want_sleep = 1'b1;
    step(2);
    chk({3'h0, slp}, 4'h0);
    step(1);
    chk({slp, clk_en}, 4'h8);
    chk({1'b0, snp_en, pll, busclk}, 4'h3);
    taken(2'h0);
    want_stop = 1'b0;
    step(4);
    chk({slp, clk_en}, 4'h8);
    want_sleep = 1'b0;
    step(3);
    chk({slp, clk_en}, 4'h3);
    step(1);
    chk({exe, clk_en}, 4'hf);
    $display("Sleep test done");
  endtask

  task automatic t_early();
    early = 1'b1;
    want_sleep = 1'b1;
    step(5);
    chk({2'h0, exe, slp}, 4'h2);
    want_stop = 1'b1;
    step(5);
    chk({slp, clk_en}, 4'h8);
    want_stop = 1'b0;
    want_sleep = 1'b0;
    early = 1'b0;
    nrst_in = 1'b0;
    step(1);
    chk({exe, clk_en}, 4'hf);
    nrst_in = 1'b1;
    step(4);
    chk({exe, clk_en}, 4'hf);
    $display("Early sleep and reset test done");
  endtask

  initial begin
    t_reset();
    t_stop();
    t_sleep();
    t_early();
    end_sim();
  end
endmodule
`default_nettype wire
